/* File: scd_pkg.sv */
// Constants and types for the synchronous DRAM command decoder.
// Assumes a single 100 MHz clock; asynchronous pin inputs are synchronised inside the decoder.
// Functional notes
// - Command pins sampled only on rising clock
// - Strobe patterns decode into the command set
// - Ordinary commands need previous clock gate high
// - Current clock gate splits refresh/self-refresh
// - Burst stop only during full-page burst
// - Clock gate low in burst means suspend
// - Precharge: auto-close bit selects one/all banks
// - Read/write auto-close bit requests auto-precharge
`default_nettype none

package scd_pkg;

    // ==========================================================
    // Sizes
    localparam int SCD_BANKS     = 4;
    localparam int SCD_ADDR_W    = 13;
    localparam int SCD_AUTO_BIT  = 10;
    localparam int SCD_BURST_DEF = 4;

    // ==========================================================
    // Decoded commands, one-hot
    typedef enum logic [10:0] {
        SCD_CMD_NONE     = 11'h001,
        SCD_CMD_ACT      = 11'h002,
        SCD_CMD_PRE      = 11'h004,
        SCD_CMD_READ     = 11'h008,
        SCD_CMD_WRITE    = 11'h010,
        SCD_CMD_MRS      = 11'h020,
        SCD_CMD_REF      = 11'h040,
        SCD_CMD_SELF     = 11'h080,
        SCD_CMD_STOP     = 11'h100,
        SCD_CMD_NOP      = 11'h200,
        SCD_CMD_DESEL    = 11'h400
    } scd_cmd_type;

    // ==========================================================
    // Device power state, one-hot
    typedef enum logic [3:0] {
        SCD_ST_RUN     = 4'h1,
        SCD_ST_SUSPEND = 4'h2,
        SCD_ST_PDOWN   = 4'h4,
        SCD_ST_SELF    = 4'h8
    } scd_state_type;

endpackage

`default_nettype wire

/* File: scd_sync.sv */
// Two flip-flop synchroniser for a bus of pin levels.
// Assumes the pins are asynchronous to clk.
`default_nettype none

module scd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    timeunit 1ns;
    timeprecision 100ps;

    // Refuse an empty bus
    if (WIDTH < 1) begin : g_width_check
        $error("scd_sync: WIDTH must be at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } scd_sync_type;

    scd_sync_type state;
    scd_sync_type next_state;

    // ==========================================================
    // Next state: first stage read only by the second
    always_comb begin
        next_state      = state;
        next_state.meta = pin;
        next_state.held = state.meta;
    end

    // Register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.held;
endmodule

`default_nettype wire

/* File: scd_decoder.sv */
// Command decoder of a synchronous DRAM: decodes control pins per clock.
// Assumes pins come from an outside controller, asynchronous to clk.
`default_nettype none

module scd_decoder #(
    parameter int BURST_LEN = scd_pkg::SCD_BURST_DEF,
    parameter bit FULL_PAGE = 1'b0
) (
    input  wire logic                            clk,
    input  wire logic                            rst_b,
    input  wire logic                            chip_sel_b,
    input  wire logic                            row_strobe_b,
    input  wire logic                            col_strobe_b,
    input  wire logic                            write_en_b,
    input  wire logic                            clock_gate_now,
    input  wire logic                            bank_select_lo,
    input  wire logic                            bank_select_hi,
    input  wire logic [scd_pkg::SCD_ADDR_W-1:0]  addr,
    input  wire logic                            low_byte_mask,
    input  wire logic                            high_byte_mask,
    output logic      [10:0]                     cmd,
    output logic                                 cmd_illegal,
    output logic      [1:0]                      cmd_bank,
    output logic      [scd_pkg::SCD_BANKS-1:0]   bank_open,
    output logic                                 auto_close,
    output logic                                 burst_busy,
    output logic      [3:0]                      power_state,
    output logic                                 low_byte_en,
    output logic                                 high_byte_en
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PW = 6 + scd_pkg::SCD_ADDR_W;

    // Refuse burst lengths the eight-bit beat counter cannot hold
    if (BURST_LEN < 1 || BURST_LEN > 255) begin : g_len_check
        $error("scd_decoder: BURST_LEN out of range");
    end

    typedef struct packed {
        logic                          gate_prev;
        scd_pkg::scd_cmd_type          cmd;
        logic                          illegal;
        logic [1:0]                    bank;
        logic [scd_pkg::SCD_BANKS-1:0] open;
        logic [scd_pkg::SCD_BANKS-1:0] close_pend;
        logic                          auto;
        logic [7:0]                    burst_cnt;
        logic                          burst_full;
        logic                          busy;
        scd_pkg::scd_state_type        pstate;
        logic                          lo_en;
        logic                          hi_en;
    } scd_dec_type;

    scd_dec_type state;
    scd_dec_type next_state;
    logic [PW-1:0] pins;
    logic [PW-1:0] raw;

    // ==========================================================
    // Pin synchronisation; sampling only at rising edges
    assign raw = {chip_sel_b, row_strobe_b, col_strobe_b, write_en_b,
                  clock_gate_now, bank_select_hi, addr};

    scd_sync #(.WIDTH(PW)) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   (raw),
        .level (pins)
    );

    logic                         s_cs, s_ras, s_cas, s_we, s_now;
    logic [1:0]                   s_bank;
    logic [scd_pkg::SCD_ADDR_W-1:0] s_addr;
    logic                         lo_sync, m_lo, m_hi;

    // Bank low bit and masks ride a second synchroniser
    scd_sync #(.WIDTH(3)) u_sync_b (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   ({bank_select_lo, low_byte_mask, high_byte_mask}),
        .level ({lo_sync, m_lo, m_hi})
    );

    assign {s_cs, s_ras, s_cas, s_we, s_now, s_bank[1], s_addr} = pins;
    assign s_bank[0] = lo_sync;

    // ==========================================================
    // Decode and track bank and power state
    always_comb begin
        logic                   any_open;
        logic                   in_burst;
        logic                   a10;
        scd_pkg::scd_cmd_type   c;
        logic                   bad;
        any_open   = |state.open;
        in_burst   = state.burst_cnt != 8'h00 || state.burst_full;
        a10        = s_addr[scd_pkg::SCD_AUTO_BIT];
        c          = scd_pkg::SCD_CMD_NONE;
        bad        = 1'b0;
        next_state = state;
        next_state.gate_prev = s_now;
        next_state.bank = s_bank;
        next_state.auto = 1'b0;

        case (state.pstate)
            scd_pkg::SCD_ST_RUN: begin
                if (state.gate_prev) begin
                    // Strobe decode with chip select low
                    if (s_cs) begin
                        c = scd_pkg::SCD_CMD_DESEL;
                    end else begin
                        case ({s_ras, s_cas, s_we})
                            3'b011: c = scd_pkg::SCD_CMD_ACT;
                            3'b010: c = scd_pkg::SCD_CMD_PRE;
                            3'b101: c = scd_pkg::SCD_CMD_READ;
                            3'b100: c = scd_pkg::SCD_CMD_WRITE;
                            3'b000: c = scd_pkg::SCD_CMD_MRS;
                            3'b001: c = s_now ? scd_pkg::SCD_CMD_REF
                                              : scd_pkg::SCD_CMD_SELF;
                            3'b111: c = scd_pkg::SCD_CMD_NOP;
                            default: c = scd_pkg::SCD_CMD_STOP;
                        endcase
                    end
                    case (c)
                        scd_pkg::SCD_CMD_ACT: begin
                            bad = state.open[s_bank];
                            next_state.open[s_bank] = 1'b1;
                        end
                        scd_pkg::SCD_CMD_PRE: begin
                            if (a10) begin
                                next_state.open = '0;
                            end else begin
                                next_state.open[s_bank] = 1'b0;
                            end
                        end
                        scd_pkg::SCD_CMD_READ,
                        scd_pkg::SCD_CMD_WRITE: begin
                            bad = !state.open[s_bank];
                            next_state.auto = a10;
                            next_state.close_pend = '0;
                            next_state.close_pend[s_bank] = a10;
                            next_state.burst_full = FULL_PAGE;
                            next_state.burst_cnt  = 8'(BURST_LEN);
                        end
                        scd_pkg::SCD_CMD_MRS,
                        scd_pkg::SCD_CMD_REF,
                        scd_pkg::SCD_CMD_SELF: begin
                            bad = any_open;
                            if (!any_open &&
                                c == scd_pkg::SCD_CMD_SELF) begin
                                next_state.pstate = scd_pkg::SCD_ST_SELF;
                            end
                        end
                        scd_pkg::SCD_CMD_STOP: begin
                            bad = !state.burst_full;
                            next_state.burst_full = 1'b0;
                            next_state.burst_cnt  = 8'h00;
                        end
                        default: begin
                        end
                    endcase
                    // Clock gate low, other than self refresh: suspend in burst, else power-down;
                    // a burst that starts this cycle counts as running
                    if (!s_now && c != scd_pkg::SCD_CMD_SELF) begin
                        next_state.pstate =
                            (in_burst || c == scd_pkg::SCD_CMD_READ ||
                             c == scd_pkg::SCD_CMD_WRITE)
                            ? scd_pkg::SCD_ST_SUSPEND
                            : scd_pkg::SCD_ST_PDOWN;
                    end
                end
            end
            scd_pkg::SCD_ST_SUSPEND,
            scd_pkg::SCD_ST_PDOWN,
            scd_pkg::SCD_ST_SELF: begin
                // Commands ignored; exit when clock gate returns high
                if (s_now) begin
                    next_state.pstate = scd_pkg::SCD_ST_RUN;
                end
            end
            default: next_state.pstate = scd_pkg::SCD_ST_RUN;
        endcase

        // Burst progress, frozen while suspended
        if (state.pstate == scd_pkg::SCD_ST_RUN &&
            c != scd_pkg::SCD_CMD_READ && c != scd_pkg::SCD_CMD_WRITE &&
            state.burst_cnt != 8'h00 && !state.burst_full) begin
            next_state.burst_cnt = state.burst_cnt - 8'h01;
            if (state.burst_cnt == 8'h01) begin
                // Auto-close, but a bank activated this cycle stays open
                next_state.open = next_state.open & ~(state.close_pend &
                    ~(next_state.open & ~state.open));
                next_state.close_pend = '0;
            end
        end

        // Burst flag registered so the output comes from a flip-flop
        next_state.busy = next_state.burst_cnt != 8'h00 ||
                          next_state.burst_full;
        next_state.cmd     = c;
        next_state.illegal = bad;
        // Mask low enables data only while any bank is open
        next_state.lo_en = !m_lo && |next_state.open;
        next_state.hi_en = !m_hi && |next_state.open;
    end

    // Register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state        <= '0;
            state.cmd    <= scd_pkg::SCD_CMD_NONE;
            state.pstate <= scd_pkg::SCD_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    assign cmd          = state.cmd;
    assign cmd_illegal  = state.illegal;
    assign cmd_bank     = state.bank;
    assign bank_open    = state.open;
    assign auto_close   = state.auto;
    assign burst_busy   = state.busy;
    assign power_state  = state.pstate;
    assign low_byte_en  = state.lo_en;
    assign high_byte_en = state.hi_en;
endmodule

`default_nettype wire

/* File: scd_decoder_monitor.sv */
// Concurrent checks on the command decoder's ports.
// Assumes pin effects show three edges after the pins change.
`default_nettype none

module scd_decoder_monitor #(
    parameter bit FULL_PAGE = 1'b0
) (
    input wire logic                           clk,
    input wire logic                           rst_b,
    input wire logic                           chip_sel_b,
    input wire logic                           row_strobe_b,
    input wire logic                           col_strobe_b,
    input wire logic                           write_en_b,
    input wire logic                           clock_gate_now,
    input wire logic [scd_pkg::SCD_ADDR_W-1:0] addr,
    input wire logic [10:0]                    cmd,
    input wire logic                           cmd_illegal,
    input wire logic [scd_pkg::SCD_BANKS-1:0]  bank_open,
    input wire logic                           auto_close,
    input wire logic                           burst_busy,
    input wire logic [3:0]                     power_state,
    input wire logic                           low_byte_en,
    input wire logic                           low_byte_mask
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Strobes as one vector: select, row, column, write
    wire logic [3:0] pins;
    assign pins = {chip_sel_b, row_strobe_b, col_strobe_b, write_en_b};

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    act_pattern_a: assert property (
        cmd == scd_pkg::SCD_CMD_ACT |-> $past(pins, 3) == 4'h3)
        else $error("activate without its pattern");
    read_pattern_a: assert property (
        cmd == scd_pkg::SCD_CMD_READ |-> $past(pins, 3) == 4'h5)
        else $error("read without its pattern");
    prev_gate_a: assert property (
        cmd != scd_pkg::SCD_CMD_NONE |-> $past(clock_gate_now, 4))
        else $error("command taken with previous gate low");
    refresh_gate_a: assert property (
        cmd == scd_pkg::SCD_CMD_REF |-> $past(clock_gate_now, 3))
        else $error("refresh with gate low");
    self_gate_a: assert property (
        cmd == scd_pkg::SCD_CMD_SELF |-> !$past(clock_gate_now, 3))
        else $error("self refresh with gate high");
    stop_page_a: assert property (
        cmd == scd_pkg::SCD_CMD_STOP
        |-> cmd_illegal == !(FULL_PAGE && $past(burst_busy)))
        else $error("burst stop legality wrong");
    pdown_idle_a: assert property (
        power_state == 4'h4 |-> !burst_busy)
        else $error("power down during a burst");
    pre_all_a: assert property (
        cmd == scd_pkg::SCD_CMD_PRE && $past(addr[10], 3)
        |-> bank_open == 4'h0) else $error("precharge all left banks open");
    auto_bit_a: assert property (
        auto_close |-> $past(addr[10], 3))
        else $error("auto close without its address bit");
    mask_open_a: assert property (
        low_byte_en == (bank_open != 4'h0 && !$past(low_byte_mask, 3)))
        else $error("low byte enable disagrees with mask and banks");
endmodule

bind scd_decoder scd_decoder_monitor #(.FULL_PAGE(FULL_PAGE)) u_mon (
    .clk, .rst_b, .chip_sel_b, .row_strobe_b, .col_strobe_b, .write_en_b,
    .clock_gate_now, .addr, .cmd, .cmd_illegal, .bank_open, .auto_close,
    .burst_busy, .power_state, .low_byte_en, .low_byte_mask);

`default_nettype wire

/* File: scd_ctrl_model.sv */
// Behavioural memory controller driving the decoder's pins.
// Assumes its tasks are called from one process of the bench.
`default_nettype none

module scd_ctrl_model (
    input  wire logic        clk,
    output logic      [3:0]  pins,
    output logic      [1:0]  bank,
    output logic      [12:0] addr,
    output logic             gate,
    output logic      [1:0]  mask
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] open_bank = 4'h0;
    logic       gate_req  = 1'b1;

    // ==========================================================
    // Idle pin levels at time zero
    initial begin
        pins = 4'hF;
        bank = 2'h0;
        addr = 13'h0000;
        gate = 1'b1;
        mask = 2'h3;
    end

    // Drive one command just after an edge
    task automatic send(input logic [3:0] p, input logic [1:0] b,
                        input logic a10);
        @(posedge clk);
        #1;
        if (p[3:1] == 3'b010 && !open_bank[b]) p = 4'h7;
        // Bank book-keeping only for commands the decoder will take
        if (gate) begin
            if (p == 4'h3) open_bank[b] = 1'b1;
            if (p == 4'h2 && a10) open_bank = 4'h0;
            if (p == 4'h2 || (p[3:1] == 3'b010 && a10)) open_bank[b] = 1'b0;
        end
        pins = p;
        bank = b;
        addr = {2'h0, a10, 10'h155};
        gate = gate_req;
    endtask

    // Deselect; released address lines show a changing pattern
    task automatic idle();
        @(posedge clk);
        #1;
        pins = {1'b1, ~pins[2:0]};
        addr = ~addr;
        gate = gate_req;
    endtask
endmodule

`default_nettype wire

/* File: scd_decoder_tb.sv */
// Self-checking bench for the command decoder.
// Assumes the monitor is bound from its own file.
`default_nettype none

module scd_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  pins, bank_open, power_state;
    logic [1:0]  bank, mask, cmd_bank;
    logic [12:0] addr;
    logic [10:0] cmd;
    logic        gate, cmd_illegal, auto_close, burst_busy;
    logic        low_byte_en, high_byte_en;
    int          fail_count = 0;
    int          n_checks = 0;

    scd_ctrl_model u_ctrl (.clk, .pins, .bank, .addr, .gate, .mask);
    scd_decoder u_dut (.clk, .rst_b, .chip_sel_b(pins[3]),
        .row_strobe_b(pins[2]), .col_strobe_b(pins[1]),
        .write_en_b(pins[0]), .clock_gate_now(gate),
        .bank_select_lo(bank[0]), .bank_select_hi(bank[1]), .addr,
        .low_byte_mask(mask[0]), .high_byte_mask(mask[1]), .cmd,
        .cmd_illegal, .cmd_bank, .bank_open, .auto_close, .burst_busy,
        .power_state, .low_byte_en, .high_byte_en);

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [10:0] exp,
                       input logic [10:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One command, a deselect, then its decode three edges on
    task automatic run(input logic [3:0] p, input logic [1:0] b,
                       input logic a10, input logic [10:0] exp);
        u_ctrl.send(p, b, a10);
        u_ctrl.idle();
        repeat (2) @(posedge clk);
        #1;
        chk("cmd", exp, cmd);
    endtask

    task automatic s_decode();
        chk("cmd", scd_pkg::SCD_CMD_NONE, cmd);
        run(4'h3, 2'h2, 1'b0, scd_pkg::SCD_CMD_ACT);
        chk("bank", 11'h2, {9'h0, cmd_bank});
        chk("open", 11'h4, {7'h0, bank_open});
        run(4'h4, 2'h2, 1'b0, scd_pkg::SCD_CMD_WRITE);
        run(4'h5, 2'h2, 1'b0, scd_pkg::SCD_CMD_READ);
        chk("illegal", 11'h0, {10'h0, cmd_illegal});
        run(4'h7, 2'h0, 1'b0, scd_pkg::SCD_CMD_NOP);
        run(4'h6, 2'h0, 1'b0, scd_pkg::SCD_CMD_STOP);
        chk("illegal", 11'h1, {10'h0, cmd_illegal});
        run(4'h2, 2'h2, 1'b0, scd_pkg::SCD_CMD_PRE);
        chk("open", 11'h0, {7'h0, bank_open});
        run(4'h0, 2'h0, 1'b0, scd_pkg::SCD_CMD_MRS);
        run(4'h1, 2'h0, 1'b0, scd_pkg::SCD_CMD_REF);
        run(4'h8, 2'h0, 1'b0, scd_pkg::SCD_CMD_DESEL);
    endtask

    task automatic s_power();
        u_ctrl.gate_req = 1'b0;
        run(4'h1, 2'h0, 1'b0, scd_pkg::SCD_CMD_SELF);
        @(posedge clk);
        #1;
        chk("state", 11'h8, {7'h0, power_state});
        u_ctrl.gate_req = 1'b1;
        u_ctrl.idle();
        u_ctrl.gate_req = 1'b0;
        run(4'h7, 2'h0, 1'b0, scd_pkg::SCD_CMD_NOP);
        @(posedge clk);
        #1;
        chk("state", 11'h4, {7'h0, power_state});
        u_ctrl.gate_req = 1'b1;
        run(4'h3, 2'h0, 1'b0, scd_pkg::SCD_CMD_NONE);
        chk("state", 11'h1, {7'h0, power_state});
    endtask

    task automatic s_burst();
        run(4'h3, 2'h1, 1'b0, scd_pkg::SCD_CMD_ACT);
        u_ctrl.send(4'h5, 2'h1, 1'b1);
        u_ctrl.gate_req = 1'b0;
        u_ctrl.idle();
        repeat (2) @(posedge clk);
        #1;
        chk("cmd", scd_pkg::SCD_CMD_READ, cmd);
        chk("auto", 11'h1, {10'h0, auto_close});
        chk("busy", 11'h1, {10'h0, burst_busy});
        repeat (2) @(posedge clk);
        #1;
        chk("state", 11'h2, {7'h0, power_state});
        chk("busy", 11'h1, {10'h0, burst_busy});
        chk("open", 11'h2, {7'h0, bank_open});
        u_ctrl.gate_req = 1'b1;
        u_ctrl.idle();
        repeat (10) @(posedge clk);
        #1;
        chk("open", 11'h0, {7'h0, bank_open});
        chk("busy", 11'h0, {10'h0, burst_busy});
    endtask

    task automatic s_banks();
        u_ctrl.mask = 2'h2;
        run(4'h3, 2'h0, 1'b0, scd_pkg::SCD_CMD_ACT);
        run(4'h3, 2'h3, 1'b0, scd_pkg::SCD_CMD_ACT);
        chk("open", 11'h9, {7'h0, bank_open});
        chk("lo_en", 11'h1, {10'h0, low_byte_en});
        chk("hi_en", 11'h0, {10'h0, high_byte_en});
        run(4'h2, 2'h0, 1'b1, scd_pkg::SCD_CMD_PRE);
        @(posedge clk);
        #1;
        chk("open", 11'h0, {7'h0, bank_open});
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial forever #5 clk = ~clk;

    initial begin
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        s_decode();
        s_power();
        s_burst();
        s_banks();
        stop_test();
    end

    initial begin
        #20us;
        fail_count++;
        stop_test();
    end
endmodule

`default_nettype wire
